// ==== design/pmm_pkg.sv ====
// constants and types shared by the program memory map loader
package pmm_pkg;
    // ************************************************************
    // program memory layout
    // ************************************************************
    localparam int PMM_AW = 24; // byte-style program address width
    localparam int PMM_WW = 23; // flash word index width
    localparam int PMM_IW = 24; // instruction word width
    localparam logic [7:0] PMM_PHANTOM = 8'h00; // unimplemented top byte
    localparam logic [23:0] PMM_PC_STEP = 24'h000002;
    localparam logic [23:0] PMM_RESET_VEC = 24'h000000;
    localparam logic [23:0] PMM_START_PTR = 24'h000002;
    localparam logic [23:0] PMM_IVT_BASE = 24'h000004;
    localparam logic [23:0] PMM_IVT_END = 24'h0000FF;
    localparam logic [23:0] PMM_ALTERNATE_VECTOR_TABLE_BASE = 24'h000100;
    localparam logic [23:0] PMM_ALTERNATE_VECTOR_TABLE_END = 24'h0001FF;
    localparam logic [23:0] PMM_RESV_END = 24'h000200;
    localparam logic [6:0] PMM_VEC_COUNT = 7'h7E; // entries per table
    localparam int PMM_ALT_BIT = 15; // alt_vector_select position

    // ************************************************************
    // configuration word locations by memory size
    // ************************************************************
    localparam logic [23:0] PMM_CFG_5K5 = 24'h002BFC;
    localparam logic [23:0] PMM_CFG_11K = 24'h0057FC;
    localparam logic [23:0] PMM_CFG_16K = 24'h0083FC;
    localparam logic [23:0] PMM_CFG_22K = 24'h00ABFC;
    localparam logic [23:0] PMM_CFG_NEXT = 24'h000002;
    localparam logic [15:0] PMM_CFG_RESET = 16'h0000;

    typedef enum logic [1:0] {
        PMM_SIZE_5K5 = 2'h0,
        PMM_SIZE_11K = 2'h1,
        PMM_SIZE_16K = 2'h2,
        PMM_SIZE_22K = 2'h3
    } pmm_size_t;

    // first configuration word address for a memory size
    function automatic logic [23:0] pmm_cfg_addr(input pmm_size_t s);
        case (s)
            PMM_SIZE_5K5: pmm_cfg_addr = PMM_CFG_5K5;
            PMM_SIZE_11K: pmm_cfg_addr = PMM_CFG_11K;
            PMM_SIZE_16K: pmm_cfg_addr = PMM_CFG_16K;
            default: pmm_cfg_addr = PMM_CFG_22K;
        endcase
    endfunction
endpackage

// ==== design/pmm_ld_if.sv ====
// carrier between the loader sequencer and the memory map front end
`timescale 1ns/1ps
interface pmm_ld_if;
    logic req;
    logic [22:0] waddr;
    logic [23:0] rdata;
    logic done;
    logic [23:0] word0;
    logic [23:0] word1;
    modport loader (output req, waddr, done, word0, word1, input rdata);
    modport front (input req, waddr, done, word0, word1, output rdata);
endinterface

// ==== design/pmm_cfg_fetch.sv ====
// reset-time reader of the two configuration words
`timescale 1ns/1ps
module pmm_cfg_fetch
    import pmm_pkg::*;
#(
    parameter pmm_pkg::pmm_size_t MEM_SIZE = pmm_pkg::PMM_SIZE_11K
) (
    // clock and reset
    input wire logic clk,
    input wire logic rstn,
    // flash path shared with the front end
    pmm_ld_if.loader ld
);
    // ************************************************************
    // sequencer
    // ************************************************************
    typedef enum logic [2:0] {
        PMM_C_RD0 = 3'h0,
        PMM_C_WT0 = 3'h1,
        PMM_C_CP0 = 3'h2,
        PMM_C_RD1 = 3'h3,
        PMM_C_WT1 = 3'h4,
        PMM_C_CP1 = 3'h5,
        PMM_C_DONE = 3'h6
    } pmm_cstate_t;

    localparam logic [23:0] CFG_A0 = pmm_cfg_addr(MEM_SIZE);
    localparam logic [23:0] CFG_A1 = CFG_A0 + PMM_CFG_NEXT;

    pmm_cstate_t state_q, state_d;
    logic [23:0] w0_q, w0_d, w1_q, w1_d;

    // the front end registers req, so data lands two states later
    always_comb begin
        state_d = state_q;
        w0_d = w0_q;
        w1_d = w1_q;
        case (state_q)
            PMM_C_RD0: state_d = PMM_C_WT0;
            PMM_C_WT0: state_d = PMM_C_CP0;
            PMM_C_CP0: begin
                w0_d = ld.rdata;
                state_d = PMM_C_RD1;
            end
            PMM_C_RD1: state_d = PMM_C_WT1;
            PMM_C_WT1: state_d = PMM_C_CP1;
            PMM_C_CP1: begin
                w1_d = ld.rdata;
                state_d = PMM_C_DONE;
            end
            PMM_C_DONE: state_d = PMM_C_DONE;
            default: state_d = PMM_C_RD0;
        endcase
    end

    // restarts only through reset, so every reset reloads
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state_q <= PMM_C_RD0;
            w0_q <= 24'h000000;
            w1_q <= 24'h000000;
        end else begin
            state_q <= state_d;
            w0_q <= w0_d;
            w1_q <= w1_d;
        end
    end

    // word addresses drop bit 0, the lower-word byte lane
    assign ld.req = (state_q == PMM_C_RD0) || (state_q == PMM_C_RD1);
    assign ld.waddr = (state_q == PMM_C_RD1) ? CFG_A1[23:1] : CFG_A0[23:1];
    assign ld.done = (state_q == PMM_C_DONE);
    assign ld.word0 = w0_q;
    assign ld.word1 = w1_q;

    // ************************************************************
    // checks
    // ************************************************************
    // anchored on the first advance: the reset state lingers one edge
    cfg_addr_a: assert property (@(posedge clk) disable iff (!rstn)
        (state_q == PMM_C_WT0) |-> ($past(ld.waddr) == CFG_A0[23:1])
        ##2 (ld.req && ld.waddr == CFG_A1[23:1]))
        else $error("second config word not two past the first");
endmodule // pmm_cfg_fetch

// ==== design/pmm_loader.sv ====
// program memory map front end: reset load, fetch, vectors, reads
`timescale 1ns/1ps
module pmm_loader
    import pmm_pkg::*;
#(
    parameter pmm_pkg::pmm_size_t MEM_SIZE = pmm_pkg::PMM_SIZE_11K
) (
    // clock and reset
    input wire logic clk,
    input wire logic rstn,
    // core requests, one-cycle pulses taken while ready_q
    input wire logic fetch_req,
    input wire logic step_up,
    input wire logic step_down,
    input wire logic jump_req,
    input wire logic [pmm_pkg::PMM_AW-1:0] jump_addr,
    input wire logic data_req,
    input wire logic [pmm_pkg::PMM_AW-1:0] data_addr,
    input wire logic vec_req,
    input wire logic [6:0] vec_num,
    input wire logic [15:0] interrupt_control_two,
    // core answers
    output logic core_run_q,
    output logic ready_q,
    output logic [pmm_pkg::PMM_AW-1:0] pc_q,
    output logic in_vectors_q,
    output logic fetch_ack_q,
    output logic [pmm_pkg::PMM_IW-1:0] instr_q,
    output logic data_ack_q,
    output logic [15:0] data_rdata_q,
    output logic vec_ack_q,
    output logic vec_err_q,
    // configuration registers
    output logic [15:0] cfg_reg0_q,
    output logic [15:0] cfg_reg1_q,
    output logic [15:0] cfg_reg2_q,
    // flash array, data one cycle after flash_rd_q
    output logic flash_rd_q,
    output logic [pmm_pkg::PMM_WW-1:0] flash_waddr_q,
    input wire logic [pmm_pkg::PMM_IW-1:0] flash_rdata
);
    import pmm_pkg::*;

    // ************************************************************
    // elaboration checks and helpers
    // ************************************************************
    if (PMM_IW != 24) begin : g_bad_width
        $error("instruction width must be 24");
    end

    // packed config bits do not follow register layout
    function automatic logic [47:0] unpack_cfg(input logic [23:0] w0,
                                               input logic [23:0] w1);
        unpack_cfg = {w0[7:0], w1[7:0], w0[15:8], w1[15:8],
                      w1[23:16], w0[23:16]};
    endfunction

    // vector table entry for a source number
    function automatic logic [23:0] vec_addr(input logic alt,
                                             input logic [6:0] n);
        vec_addr = (alt ? PMM_ALTERNATE_VECTOR_TABLE_BASE : PMM_IVT_BASE)
                   + {16'h0000, n, 1'b0};
    endfunction

    pmm_ld_if ld();

    pmm_cfg_fetch #(.MEM_SIZE(MEM_SIZE)) u_cfg (
        .clk(clk),
        .rstn(rstn),
        .ld(ld)
    );

    assign ld.rdata = flash_rdata;

    // ************************************************************
    // access sequencer
    // ************************************************************
    typedef enum logic [2:0] {
        PMM_S_LOAD = 3'h0,
        PMM_S_IDLE = 3'h1,
        PMM_S_WAIT = 3'h2,
        PMM_S_CAPT = 3'h3
    } pmm_state_t;

    typedef enum logic [1:0] {
        PMM_K_FETCH = 2'h0,
        PMM_K_DATA = 2'h1,
        PMM_K_VEC = 2'h2
    } pmm_kind_t;

    pmm_state_t state_q, state_d;
    pmm_kind_t kind_q, kind_d;
    logic run_d, rd_d, fack_d, dack_d, vack_d, verr_d, dsel_q, dsel_d;
    logic [23:0] pc_d, instr_d;
    logic [22:0] waddr_d;
    logic [15:0] drd_d;
    logic [47:0] cfg_q, cfg_d;
    logic alt_sel;
    logic [23:0] vec_a;

    assign alt_sel = interrupt_control_two[PMM_ALT_BIT];
    // entry address kept as a net so its word index can be sliced
    assign vec_a = vec_addr(alt_sel, vec_num);

    // priority in idle: vector, jump, step up, step down, data, fetch
    always_comb begin
        state_d = state_q;
        kind_d = kind_q;
        run_d = core_run_q;
        pc_d = pc_q;
        instr_d = instr_q;
        drd_d = data_rdata_q;
        dsel_d = dsel_q;
        cfg_d = cfg_q;
        rd_d = 1'b0;
        waddr_d = flash_waddr_q;
        fack_d = 1'b0;
        dack_d = 1'b0;
        vack_d = 1'b0;
        verr_d = 1'b0;
        case (state_q)
            PMM_S_LOAD: begin
                rd_d = ld.req;
                waddr_d = ld.waddr;
                if (ld.done) begin
                    cfg_d = unpack_cfg(ld.word0, ld.word1);
                    run_d = 1'b1;
                    pc_d = PMM_RESET_VEC;
                    state_d = PMM_S_IDLE;
                end
            end
            PMM_S_IDLE: begin
                if (vec_req) begin
                    if (vec_num >= PMM_VEC_COUNT) begin
                        vack_d = 1'b1;
                        verr_d = 1'b1;
                    end else begin
                        rd_d = 1'b1;
                        waddr_d = vec_a[23:1];
                        kind_d = PMM_K_VEC;
                        state_d = PMM_S_WAIT;
                    end
                end else if (jump_req) begin
                    pc_d = {jump_addr[23:1], 1'b0};
                end else if (step_up) begin
                    pc_d = pc_q + PMM_PC_STEP;
                end else if (step_down) begin
                    pc_d = pc_q - PMM_PC_STEP;
                end else if (data_req) begin
                    rd_d = 1'b1;
                    waddr_d = data_addr[23:1];
                    dsel_d = data_addr[0];
                    kind_d = PMM_K_DATA;
                    state_d = PMM_S_WAIT;
                end else if (fetch_req) begin
                    rd_d = 1'b1;
                    waddr_d = pc_q[23:1];
                    kind_d = PMM_K_FETCH;
                    state_d = PMM_S_WAIT;
                end
            end
            PMM_S_WAIT: state_d = PMM_S_CAPT;
            PMM_S_CAPT: begin
                state_d = PMM_S_IDLE;
                case (kind_q)
                    PMM_K_VEC: begin
                        pc_d = {flash_rdata[23:1], 1'b0};
                        vack_d = 1'b1;
                    end
                    PMM_K_DATA: begin
                        // odd address: phantom byte over upper bits
                        drd_d = dsel_q ? {PMM_PHANTOM, flash_rdata[23:16]}
                                       : flash_rdata[15:0];
                        dack_d = 1'b1;
                    end
                    default: begin
                        instr_d = flash_rdata;
                        fack_d = 1'b1;
                    end
                endcase
            end
            default: state_d = PMM_S_LOAD;
        endcase
    end

    // registers cleared on every reset except in_vectors_q, which is set; core held until load ends
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state_q <= PMM_S_LOAD;
            kind_q <= PMM_K_FETCH;
            core_run_q <= 1'b0;
            ready_q <= 1'b0;
            pc_q <= PMM_RESET_VEC;
            in_vectors_q <= 1'b1;
            instr_q <= 24'h000000;
            data_rdata_q <= 16'h0000;
            dsel_q <= 1'b0;
            cfg_q <= {PMM_CFG_RESET, PMM_CFG_RESET, PMM_CFG_RESET};
            flash_rd_q <= 1'b0;
            flash_waddr_q <= 23'h000000;
            fetch_ack_q <= 1'b0;
            data_ack_q <= 1'b0;
            vec_ack_q <= 1'b0;
            vec_err_q <= 1'b0;
        end else begin
            state_q <= state_d;
            kind_q <= kind_d;
            core_run_q <= run_d;
            ready_q <= (state_d == PMM_S_IDLE);
            pc_q <= pc_d;
            in_vectors_q <= (pc_d < PMM_RESV_END);
            instr_q <= instr_d;
            data_rdata_q <= drd_d;
            dsel_q <= dsel_d;
            cfg_q <= cfg_d;
            flash_rd_q <= rd_d;
            flash_waddr_q <= waddr_d;
            fetch_ack_q <= fack_d;
            data_ack_q <= dack_d;
            vec_ack_q <= vack_d;
            vec_err_q <= verr_d;
        end
    end

    assign cfg_reg0_q = cfg_q[47:32];
    assign cfg_reg1_q = cfg_q[31:16];
    assign cfg_reg2_q = cfg_q[15:0];

    // ************************************************************
    // checks
    // ************************************************************
    phantom_zero_a: assert property (@(posedge clk) disable iff (!rstn)
        (data_ack_q && dsel_q) |-> (data_rdata_q[15:8] == PMM_PHANTOM))
        else $error("phantom byte not zero");

    lane_map_a: assert property (@(posedge clk) disable iff (!rstn)
        (ready_q && data_req && !vec_req && !jump_req && !step_up
         && !step_down) |=> (flash_rd_q
         && flash_waddr_q == $past(data_addr[23:1])) ##2 data_ack_q)
        else $error("data read lane or timing wrong");

    step_two_a: assert property (@(posedge clk) disable iff (!rstn)
        (ready_q && step_up && !vec_req && !jump_req)
        |=> (pc_q == $past(pc_q) + PMM_PC_STEP) && (pc_q[0] == 1'b0))
        else $error("pc did not step by two");

    resv_flag_a: assert property (@(posedge clk) disable iff (!rstn)
        in_vectors_q == (pc_q[23:9] == 15'h0000))
        else $error("vector region flag wrong");

    start_pc_a: assert property (@(posedge clk) disable iff (!rstn)
        $rose(core_run_q) |-> (pc_q == PMM_RESET_VEC) && ready_q)
        else $error("core released away from reset vector");

    vec_table_a: assert property (@(posedge clk) disable iff (!rstn)
        (ready_q && vec_req && vec_num < PMM_VEC_COUNT)
        |=> flash_rd_q && (flash_waddr_q[22:8] == 15'h0000)
            && (flash_waddr_q[7] == $past(alt_sel)) ##2 vec_ack_q)
        else $error("vector fetched from wrong table");

    cfg_copy_a: assert property (@(posedge clk) disable iff (!rstn)
        $rose(core_run_q) |-> (cfg_reg2_q == {ld.word1[23:16],
                                              ld.word0[23:16]}))
        else $error("config words not copied");

    hold_core_a: assert property (@(posedge clk) disable iff (!rstn)
        !ld.done |-> !core_run_q && !ready_q)
        else $error("core released before config load");
endmodule // pmm_loader

// ==== test/pmm_flash_model.sv ====
// flash array model standing behind the loader's read port
`timescale 1ns/1ps
module pmm_flash_model (
    // clock
    input wire logic clk,
    // read port
    input wire logic rd,
    input wire logic [22:0] waddr,
    output logic [23:0] rdata
);
    // ************************************************************
    // contents and read timing
    // ************************************************************
    // pattern with a top byte that changes per word, 24 bits each
    function automatic logic [23:0] flash_word(input logic [22:0] w);
        flash_word = {w[7:0] ^ 8'hC3, w[15:0] ^ 16'h5A96};
    endfunction

    initial rdata = 24'h000000;

    // valid only in the cycle after the strobe; flipping otherwise
    // so a late sample never sees a stale but plausible word
    always @(posedge clk) begin
        if (rd) begin
            rdata <= flash_word(waddr);
        end else begin
            rdata <= ~rdata;
        end
    end
endmodule // pmm_flash_model

// ==== test/tb.sv ====
// self-checking bench for the program memory map loader
`timescale 1ns/1ps
module tb;
    import pmm_pkg::*;
    // ************************************************************
    // signals
    // ************************************************************
    logic clk, rstn, fetch_req, step_up, step_down, jump_req;
    logic data_req, vec_req;
    logic [23:0] jump_addr, data_addr;
    logic [6:0] vec_num;
    logic [15:0] ictl;
    logic core_run_q, ready_q, in_vectors_q, fetch_ack_q, data_ack_q;
    logic vec_ack_q, vec_err_q, flash_rd_q;
    logic [23:0] pc_q, instr_q, flash_rdata;
    logic [15:0] data_rdata_q, cfg_reg0_q, cfg_reg1_q, cfg_reg2_q;
    logic [22:0] flash_waddr_q;
    int n_fail = 0;
    int n_tests = 0;

    pmm_loader #(.MEM_SIZE(PMM_SIZE_11K)) u_dut (
        .clk(clk), .rstn(rstn), .fetch_req(fetch_req),
        .step_up(step_up), .step_down(step_down), .jump_req(jump_req),
        .jump_addr(jump_addr), .data_req(data_req),
        .data_addr(data_addr), .vec_req(vec_req), .vec_num(vec_num),
        .interrupt_control_two(ictl), .core_run_q(core_run_q),
        .ready_q(ready_q), .pc_q(pc_q), .in_vectors_q(in_vectors_q),
        .fetch_ack_q(fetch_ack_q), .instr_q(instr_q),
        .data_ack_q(data_ack_q), .data_rdata_q(data_rdata_q),
        .vec_ack_q(vec_ack_q), .vec_err_q(vec_err_q),
        .cfg_reg0_q(cfg_reg0_q), .cfg_reg1_q(cfg_reg1_q),
        .cfg_reg2_q(cfg_reg2_q), .flash_rd_q(flash_rd_q),
        .flash_waddr_q(flash_waddr_q), .flash_rdata(flash_rdata)
    );

    pmm_flash_model u_flash (
        .clk(clk), .rd(flash_rd_q), .waddr(flash_waddr_q),
        .rdata(flash_rdata)
    );

    // ************************************************************
    // clock, defaults and watchdog
    // ************************************************************
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    initial begin
        rstn = 1'b0;
        {fetch_req, step_up, step_down, jump_req, data_req} = 5'h00;
        vec_req = 1'b0;
        jump_addr = 24'h000000;
        data_addr = 24'h000000;
        vec_num = 7'h00;
        ictl = 16'h0000;
    end

    // whole run is about a hundred cycles; allow forty times that
    initial begin
        #(40 * 4000);
        n_fail++;
        summarize();
    end

    // ************************************************************
    // shared tasks
    // ************************************************************
    task automatic check(input string what, input logic [23:0] got,
                         input logic [23:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask

    // one request pulse, raised once ready is seen high or after 20 cycles without it
    task automatic issue(input int k, input logic [23:0] a,
                         input logic [6:0] n);
        int i;
        for (i = 0; i < 20; i++) begin
            @(posedge clk);
            #1;
            if (ready_q === 1'b1) break;
        end
        @(posedge clk);
        case (k)
            0: fetch_req <= 1'b1;
            1: step_up <= 1'b1;
            2: step_down <= 1'b1;
            3: begin jump_req <= 1'b1; jump_addr <= a; end
            4: begin data_req <= 1'b1; data_addr <= a; end
            default: begin vec_req <= 1'b1; vec_num <= n; end
        endcase
        @(posedge clk);
        {fetch_req, step_up, step_down, jump_req, data_req} <= 5'h00;
        vec_req <= 1'b0;
    endtask

    // acks stand one cycle, so sample right after each edge;
    // count starts at the raising edge, taking edge is count one
    task automatic wait_ack(input int lat);
        int i;
        logic seen;
        #1;
        seen = fetch_ack_q | data_ack_q | vec_ack_q;
        for (i = 1; i < 8 && seen !== 1'b1; i++) begin
            @(posedge clk);
            #1;
            seen = fetch_ack_q | data_ack_q | vec_ack_q;
        end
        check("ack latency", i, lat);
    endtask

    task automatic pc_op(input int k, input logic [23:0] a,
                         input logic [23:0] exp);
        issue(k, a, 7'h00);
        @(posedge clk);
        #1;
        check("pc", pc_q, exp);
    endtask

    // ************************************************************
    // scenarios
    // ************************************************************
    task automatic t_reset();
        int n;
        logic [22:0] seen_q[$];
        logic [23:0] w0, w1;
        @(posedge clk);
        rstn <= 1'b0;
        @(posedge clk);
        #1;
        check("pc in reset", pc_q, PMM_RESET_VEC);
        check("vec flag in reset", in_vectors_q, 24'h1);
        check("run in reset", {core_run_q, ready_q}, 24'h0);
        @(posedge clk);
        rstn <= 1'b1;
        for (n = 1; n < 12; n++) begin
            @(posedge clk);
            #1;
            if (flash_rd_q === 1'b1) seen_q.push_back(flash_waddr_q);
            if (core_run_q === 1'b1) break;
        end
        check("run edge", n, 7);
        check("ready at run", ready_q, 24'h1);
        check("pc at run", pc_q, PMM_RESET_VEC);
        check("cfg reads", seen_q.size(), 2);
        w0 = u_flash.flash_word(PMM_CFG_11K[23:1]);
        w1 = u_flash.flash_word(PMM_CFG_11K[23:1] + 23'h1);
        if (seen_q.size() == 2) begin
            check("cfg addr0", seen_q[0], PMM_CFG_11K[23:1]);
            check("cfg addr1", seen_q[1], PMM_CFG_11K[23:1] + 1);
        end
        check("cfg0", cfg_reg0_q, {w0[7:0], w1[7:0]});
        check("cfg1", cfg_reg1_q, {w0[15:8], w1[15:8]});
        check("cfg2", cfg_reg2_q, {w1[23:16], w0[23:16]});
    endtask

    task automatic t_fetch();
        issue(0, 24'h0, 7'h00);
        wait_ack(3);
        check("instr at 0", instr_q, u_flash.flash_word(23'h0));
        pc_op(1, 24'h0, PMM_START_PTR);
        pc_op(1, 24'h0, 24'h000004);
        pc_op(2, 24'h0, 24'h000002);
        issue(0, 24'h0, 7'h00);
        wait_ack(3);
        check("instr at 2", instr_q, u_flash.flash_word(23'h1));
    endtask

    // both halves of one word, upper half of two more, phantom byte must read zero
    task automatic t_data();
        logic [23:0] al[4] = '{24'h000010, 24'h000011, 24'h0057FD,
                               24'h000201};
        logic [23:0] w;
        foreach (al[i]) begin
            issue(4, al[i], 7'h00);
            wait_ack(3);
            w = u_flash.flash_word(al[i][23:1]);
            if (al[i][0]) begin
                check("upper half", data_rdata_q, {8'h00, w[23:16]});
            end else begin
                check("lower half", data_rdata_q, w[15:0]);
            end
        end
    endtask

    // odd target is aligned down; flag follows the 000200h bound
    task automatic t_jump();
        logic [23:0] tl[3] = '{24'h000301, 24'h0001FE, 24'h000200};
        foreach (tl[i]) begin
            pc_op(3, tl[i], {tl[i][23:1], 1'b0});
            @(posedge clk);
            #1;
            check("in vectors", in_vectors_q, tl[i] < PMM_RESV_END);
        end
    endtask

    // other control bits set opposite to show only bit 15 steers
    task automatic t_vec();
        logic [6:0] nl[2] = '{7'h00, 7'h7D};
        logic [23:0] base, e;
        for (int alt = 0; alt < 2; alt++) begin
            @(posedge clk);
            ictl <= (alt == 1) ? 16'h8000 : 16'h7FFF;
            base = (alt == 1) ? PMM_ALTERNATE_VECTOR_TABLE_BASE : PMM_IVT_BASE;
            foreach (nl[i]) begin
                issue(5, 24'h0, nl[i]);
                wait_ack(3);
                e = u_flash.flash_word(23'((base + 2 * nl[i]) >> 1));
                check("vector pc", pc_q, {e[23:1], 1'b0});
                check("vector ok", vec_err_q, 24'h0);
            end
        end
        issue(5, 24'h0, PMM_VEC_COUNT);
        wait_ack(1);
        check("vector refused", vec_err_q, 24'h1);
    endtask

    task automatic summarize();
        if (n_fail == 0 && n_tests > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // ************************************************************
    // main sequence, second reset mid-run reloads configuration
    // ************************************************************
    initial begin
        t_reset();
        t_fetch();
        t_data();
        t_jump();
        t_vec();
        t_reset();
        summarize();
    end
endmodule // tb
